// ===== core/gir_defs.svh
/*
 * Offsets, field positions, reset values and codes of the guest injection restriction block.
 * Assumes a 32-bit Avalon-MM slave with byte addresses and word-aligned registers.
 */
`ifndef GIR_DEFS_SVH
`define GIR_DEFS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define GIR_OFS_FEATURE 8'h00
`define GIR_OFS_HOST_EVT 8'h04
`define GIR_OFS_HOST_VI_LO 8'h08
`define GIR_OFS_HOST_VI_HI 8'h0C
`define GIR_OFS_HOST_SHADOW 8'h10
`define GIR_OFS_ENC_EVT 8'h14
`define GIR_OFS_ENC_VI_LO 8'h18
`define GIR_OFS_ENC_VI_HI 8'h1C
`define GIR_OFS_INTERCEPT 8'h20
`define GIR_OFS_CMD 8'h24
`define GIR_OFS_EXIT_CODE 8'h28
`define GIR_OFS_IRQ_STAT 8'h2C
`define GIR_OFS_IRQ_MASK 8'h30
`define GIR_OFS_FLAGS 8'h34

// ****************************************
// Field positions
// ****************************************
`define GIR_FEAT_RESTRICT 3
`define GIR_FEAT_ALTERNATE 4
`define GIR_EVT_VEC_LSB 0
`define GIR_EVT_TYPE_LSB 8
`define GIR_EVT_ERRV 11
`define GIR_EVT_VALID 31
`define GIR_VI_TPR_LSB 0
`define GIR_VI_IRQ 8
`define GIR_VI_VIRTUAL_GLOBAL_INT_FLAG 9
`define GIR_VI_SHADOW 10
`define GIR_VI_PRIO_LSB 16
`define GIR_VI_IGN 20
`define GIR_VI_MASKING 24
`define GIR_VI_VIRTUAL_GLOBAL_INT_FLAG_MODE 25
`define GIR_VI_ACCELERATED_VIRTUAL_INT_CTRL 31
`define GIR_VI_VEC_LSB 32
`define GIR_VI_BUSY 63
`define GIR_ICPT_PROT 4
`define GIR_IRQ_PASS 0
`define GIR_IRQ_FAIL 1
`define GIR_IRQ_WBACK 2
`define GIR_FLAG_BUSY 0
`define GIR_FLAG_RESTRICT 1
`define GIR_FLAG_ALTERNATE 2

// ****************************************
// Codes and reset values
// ****************************************
`define GIR_DOORBELL_VEC 8'h1C
`define GIR_TYPE_EXCEPTION 3'h3
`define GIR_EXIT_NONE 32'h0000_0000
`define GIR_EXIT_INVALID 32'hFFFF_FFFF
`define GIR_EXIT_BUSY 32'hFFFF_FFFE
`define GIR_MSR_LO 32'h0000_0800
`define GIR_MSR_HI 32'h0000_08FF
`define GIR_RST_WORD 32'h0000_0000
`define GIR_RST_DWORD 64'h0000_0000_0000_0000

`endif

// ===== core/gir_entry_check.sv
/*
 * Combinational entry checks and source selection for a guest entry.
 * Assumes its inputs are the registers of the top and stay stable while it is read.
 */
`timescale 1ns/1ps
`include "gir_defs.svh"

module gir_entry_check (
	// Mode and host copies
	input wire logic [31:0] feature,
	input wire logic [31:0] host_evt,
	input wire logic [63:0] host_vi,
	input wire logic host_shadow,
	// Encrypted copies
	input wire logic [31:0] enc_evt,
	input wire logic [63:0] enc_vi,
	// Verdict and selected load state
	output logic fail,
	output logic [31:0] code,
	output gir_pkg::gir_load_t sel
);

	logic restrict_on;
	logic alt_on;
	logic [31:0] evt;
	logic [63:0] vi;
	logic accelerated_virtual_int_ctrl;

	assign restrict_on = feature[`GIR_FEAT_RESTRICT];
	assign alt_on = feature[`GIR_FEAT_ALTERNATE];
	assign evt = alt_on ? enc_evt : host_evt;
	assign vi = alt_on ? enc_vi : host_vi;
	assign accelerated_virtual_int_ctrl = host_vi[`GIR_VI_ACCELERATED_VIRTUAL_INT_CTRL];

	always_comb
	begin
		code = `GIR_EXIT_NONE;
		if (restrict_on && alt_on)
			code = `GIR_EXIT_INVALID;
		else if (restrict_on && (accelerated_virtual_int_ctrl || (evt[`GIR_EVT_VALID]
			&& !(gir_pkg::gir_is_doorbell(evt) && gir_pkg::gir_doorbell_form(evt)))))
			code = `GIR_EXIT_INVALID;
		else if (!restrict_on && gir_pkg::gir_is_doorbell(evt))
			code = `GIR_EXIT_INVALID;
		else if (alt_on && accelerated_virtual_int_ctrl)
			code = `GIR_EXIT_INVALID;
		else if (alt_on && enc_vi[`GIR_VI_BUSY])
			code = `GIR_EXIT_BUSY;
		fail = (code != `GIR_EXIT_NONE);
	end

	always_comb
	begin
		sel.evt_valid = evt[`GIR_EVT_VALID];
		sel.evt_vector = evt[`GIR_EVT_VEC_LSB +: 8];
		sel.evt_type = evt[`GIR_EVT_TYPE_LSB +: 3];
		sel.evt_errv = evt[`GIR_EVT_ERRV];
		sel.virtual_task_priority = vi[`GIR_VI_TPR_LSB +: 8];
		sel.v_irq = vi[`GIR_VI_IRQ] && !restrict_on;
		sel.virtual_global_int_flag = vi[`GIR_VI_VIRTUAL_GLOBAL_INT_FLAG];
		sel.v_prio = vi[`GIR_VI_PRIO_LSB +: 4];
		sel.v_ign = vi[`GIR_VI_IGN];
		sel.v_vector = vi[`GIR_VI_VEC_LSB +: 8];
		sel.shadow = alt_on ? enc_vi[`GIR_VI_SHADOW] : host_shadow;
		sel.masking = host_vi[`GIR_VI_MASKING];
		sel.virtual_global_int_flag_mode = host_vi[`GIR_VI_VIRTUAL_GLOBAL_INT_FLAG_MODE];
	end

endmodule

// ===== core/gir_intercept.sv
/*
 * Forced intercept logic for physical events and local controller register accesses.
 * Assumes event and access inputs come from logic on the same clock.
 */
`timescale 1ns/1ps
`include "gir_defs.svh"

module gir_intercept (
	// Clock, reset and enable
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	// Running mode and host intercept bits
	input wire logic guard_on,
	input wire logic alt_on,
	input wire logic [4:0] host_icpt,
	// Guest activity
	input gir_pkg::gir_event_t ev_in,
	input wire logic msr_valid,
	input wire logic [31:0] msr_addr,
	input wire logic msr_hit,
	// Intercept verdicts
	output gir_pkg::gir_event_t ev_exit,
	output logic msr_exit
);

	gir_pkg::gir_event_t next_ev_exit;
	logic next_msr_exit;
	logic in_range;

	assign in_range = (msr_addr >= `GIR_MSR_LO) && (msr_addr <= `GIR_MSR_HI);

	always_comb
	begin
		next_ev_exit = gir_pkg::gir_event_t'(ev_in & (host_icpt[3:0] | {4{guard_on}}));
		next_msr_exit = msr_valid && ((alt_on && in_range)
			|| (host_icpt[`GIR_ICPT_PROT] && msr_hit));
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			ev_exit <= '0;
			msr_exit <= 1'b0;
		end
		else if (ce)
		begin
			ev_exit <= next_ev_exit;
			msr_exit <= next_msr_exit;
		end
	end

	force_event_a: assert property (@(posedge clk) disable iff (reset)
		ce && guard_on && ev_in.nmi && ce ##1 ce |-> ev_exit.nmi)
		else $error("forced event intercept missing");

	msr_range_a: assert property (@(posedge clk) disable iff (reset)
		ce && alt_on && msr_valid && in_range |=> msr_exit || !$past(ce))
		else $error("local controller register access not intercepted");

endmodule

// ===== core/gir_pkg.sv
/*
 * Types shared by the guest injection restriction block.
 * Assumes gir_defs.svh is on the include path.
 */
`include "gir_defs.svh"

package gir_pkg;

	// ****************************************
	// Entry sequencer states
	// ****************************************
	typedef enum logic [1:0] {
		GIR_IDLE = 2'b00,
		GIR_CHECK = 2'b01,
		GIR_LOAD = 2'b11
	} gir_state_t;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic evt_valid;
		logic [7:0] evt_vector;
		logic [2:0] evt_type;
		logic evt_errv;
		logic [7:0] virtual_task_priority;
		logic v_irq;
		logic virtual_global_int_flag;
		logic [3:0] v_prio;
		logic v_ign;
		logic [7:0] v_vector;
		logic shadow;
		logic masking;
		logic virtual_global_int_flag_mode;
	} gir_load_t;

	typedef struct packed {
		logic [7:0] virtual_task_priority;
		logic v_irq;
		logic shadow;
	} gir_exit_t;

	typedef struct packed {
		logic intr;
		logic nmi;
		logic init;
		logic mcheck;
	} gir_event_t;

	// ****************************************
	// Decoding
	// ****************************************
	function automatic logic gir_is_doorbell(input logic [31:0] evt);
		gir_is_doorbell = evt[`GIR_EVT_VALID]
			&& (evt[`GIR_EVT_VEC_LSB +: 8] == `GIR_DOORBELL_VEC);
	endfunction

	function automatic logic gir_doorbell_form(input logic [31:0] evt);
		gir_doorbell_form = (evt[`GIR_EVT_TYPE_LSB +: 3] == `GIR_TYPE_EXCEPTION)
			&& !evt[`GIR_EVT_ERRV];
	endfunction

endpackage

// ===== core/gir_top.sv
/*
 * Guest entry injection policy: registers, entry sequencer, exit write-back and interrupt.
 * Assumes an Avalon-MM master with waitrequest and a core that pulses entry and exit on CLK_SYS.
 */
`timescale 1ns/1ps
`include "gir_defs.svh"

module gir_top (
	// Clock, reset and enable
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic CE,
	// Avalon-MM slave
	input wire logic [7:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	// Guest entry and exit
	output logic LOAD_VALID,
	output gir_pkg::gir_load_t LOAD_STATE,
	input wire logic EXIT_VALID,
	input gir_pkg::gir_exit_t EXIT_STATE,
	// Intercepts
	input gir_pkg::gir_event_t EVENT_IN,
	input wire logic MSR_VALID,
	input wire logic [31:0] MSR_ADDR,
	input wire logic MSR_BITMAP_HIT,
	output gir_pkg::gir_event_t EVENT_EXIT,
	output logic MSR_EXIT,
	// Interrupt
	output logic IRQ
);

	// ****************************************
	// State
	// ****************************************
	gir_pkg::gir_state_t state, next_state;
	logic ack, next_ack;
	logic [31:0] rdata, next_rdata;
	logic [31:0] feature, next_feature;
	logic [31:0] host_evt, next_host_evt;
	logic [63:0] host_vi, next_host_vi;
	logic host_shadow, next_host_shadow;
	logic [31:0] enc_evt, next_enc_evt;
	logic [63:0] enc_vi, next_enc_vi;
	logic [4:0] icpt, next_icpt;
	logic [31:0] exit_code, next_exit_code;
	logic [2:0] irq_stat, next_irq_stat;
	logic [2:0] irq_mask, next_irq_mask;
	logic [1:0] run_mode, next_run_mode;
	gir_pkg::gir_load_t load_q, next_load_q;
	logic wr;
	logic start;
	logic chk_fail;
	logic [31:0] chk_code;
	gir_pkg::gir_load_t chk_sel;

	// A read or write completes one cycle after it is raised.
	assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack;
	assign AVS_READDATA = rdata;
	assign wr = AVS_WRITE && ack;
	assign start = wr && (AVS_ADDRESS == `GIR_OFS_CMD) && AVS_BYTEENABLE[0] && AVS_WRITEDATA[0];
	assign LOAD_VALID = (state == gir_pkg::GIR_LOAD);
	assign LOAD_STATE = load_q;
	assign IRQ = |(irq_stat & irq_mask);

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] din,
		input logic [3:0] be);
		for (int i = 0; i < 4; i++)
			merge[i*8 +: 8] = be[i] ? din[i*8 +: 8] : old[i*8 +: 8];
	endfunction

	// ****************************************
	// Submodules
	// ****************************************
	gir_entry_check u_check (
		.feature(feature),
		.host_evt(host_evt),
		.host_vi(host_vi),
		.host_shadow(host_shadow),
		.enc_evt(enc_evt),
		.enc_vi(enc_vi),
		.fail(chk_fail),
		.code(chk_code),
		.sel(chk_sel)
	);

	gir_intercept u_icpt (
		.clk(CLK_SYS),
		.reset(RESET),
		.ce(CE),
		.guard_on(|run_mode),
		.alt_on(run_mode[1]),
		.host_icpt(icpt),
		.ev_in(EVENT_IN),
		.msr_valid(MSR_VALID),
		.msr_addr(MSR_ADDR),
		.msr_hit(MSR_BITMAP_HIT),
		.ev_exit(EVENT_EXIT),
		.msr_exit(MSR_EXIT)
	);

	// ****************************************
	// Bus read path
	// ****************************************
	always_comb
	begin
		next_ack = (AVS_READ || AVS_WRITE) && !ack;
		next_rdata = rdata;
		if (AVS_READ && !ack)
		begin
			unique case (AVS_ADDRESS)
				`GIR_OFS_FEATURE: next_rdata = feature;
				`GIR_OFS_HOST_EVT: next_rdata = host_evt;
				`GIR_OFS_HOST_VI_LO: next_rdata = host_vi[31:0];
				`GIR_OFS_HOST_VI_HI: next_rdata = host_vi[63:32];
				`GIR_OFS_HOST_SHADOW: next_rdata = {31'h0000_0000, host_shadow};
				`GIR_OFS_ENC_EVT: next_rdata = enc_evt;
				`GIR_OFS_ENC_VI_LO: next_rdata = enc_vi[31:0];
				`GIR_OFS_ENC_VI_HI: next_rdata = enc_vi[63:32];
				`GIR_OFS_INTERCEPT: next_rdata = {27'h000_0000, icpt};
				`GIR_OFS_EXIT_CODE: next_rdata = exit_code;
				`GIR_OFS_IRQ_STAT: next_rdata = {29'h0000_0000, irq_stat};
				`GIR_OFS_IRQ_MASK: next_rdata = {29'h0000_0000, irq_mask};
				`GIR_OFS_FLAGS: next_rdata = {29'h0000_0000, run_mode,
					state != gir_pkg::GIR_IDLE};
				default: next_rdata = 32'h0000_0000;
			endcase
		end
	end

	// ****************************************
	// Registers, sequencer and write-back
	// ****************************************
	always_comb
	begin
		next_state = state;
		next_feature = feature;
		next_host_evt = host_evt;
		next_host_vi = host_vi;
		next_host_shadow = host_shadow;
		next_enc_evt = enc_evt;
		next_enc_vi = enc_vi;
		next_icpt = icpt;
		next_exit_code = exit_code;
		next_irq_mask = irq_mask;
		next_irq_stat = irq_stat;
		next_run_mode = run_mode;
		next_load_q = load_q;
		if (wr)
		begin
			unique case (AVS_ADDRESS)
				`GIR_OFS_FEATURE: next_feature = merge(feature, AVS_WRITEDATA, AVS_BYTEENABLE);
				`GIR_OFS_HOST_EVT: next_host_evt = merge(host_evt, AVS_WRITEDATA, AVS_BYTEENABLE);
				`GIR_OFS_HOST_VI_LO: next_host_vi[31:0] = merge(host_vi[31:0], AVS_WRITEDATA,
					AVS_BYTEENABLE);
				`GIR_OFS_HOST_VI_HI: next_host_vi[63:32] = merge(host_vi[63:32], AVS_WRITEDATA,
					AVS_BYTEENABLE);
				`GIR_OFS_HOST_SHADOW: next_host_shadow = AVS_BYTEENABLE[0] ? AVS_WRITEDATA[0]
					: host_shadow;
				`GIR_OFS_ENC_EVT: next_enc_evt = merge(enc_evt, AVS_WRITEDATA, AVS_BYTEENABLE);
				`GIR_OFS_ENC_VI_LO: next_enc_vi[31:0] = merge(enc_vi[31:0], AVS_WRITEDATA,
					AVS_BYTEENABLE);
				`GIR_OFS_ENC_VI_HI: next_enc_vi[63:32] = merge(enc_vi[63:32], AVS_WRITEDATA,
					AVS_BYTEENABLE);
				`GIR_OFS_INTERCEPT: next_icpt = AVS_BYTEENABLE[0] ? AVS_WRITEDATA[4:0] : icpt;
				`GIR_OFS_IRQ_STAT: next_irq_stat = irq_stat
					& ~(AVS_BYTEENABLE[0] ? AVS_WRITEDATA[2:0] : 3'h0);
				`GIR_OFS_IRQ_MASK: next_irq_mask = AVS_BYTEENABLE[0] ? AVS_WRITEDATA[2:0]
					: irq_mask;
				default: next_irq_mask = irq_mask;
			endcase
		end
		// The guest's own exit state wins over a bus write in the same cycle.
		if (EXIT_VALID)
		begin
			if (run_mode[1])
			begin
				next_enc_vi[`GIR_VI_TPR_LSB +: 8] = EXIT_STATE.virtual_task_priority;
				next_enc_vi[`GIR_VI_IRQ] = EXIT_STATE.v_irq;
				next_enc_vi[`GIR_VI_SHADOW] = EXIT_STATE.shadow;
			end
			else
			begin
				next_host_vi[`GIR_VI_TPR_LSB +: 8] = EXIT_STATE.virtual_task_priority;
				next_host_vi[`GIR_VI_IRQ] = EXIT_STATE.v_irq;
				next_host_shadow = EXIT_STATE.shadow;
			end
			next_irq_stat[`GIR_IRQ_WBACK] = 1'b1;
		end
		unique case (state)
			gir_pkg::GIR_IDLE:
				if (start)
					next_state = gir_pkg::GIR_CHECK;
			gir_pkg::GIR_CHECK:
			begin
				next_exit_code = chk_code;
				if (chk_fail)
				begin
					next_irq_stat[`GIR_IRQ_FAIL] = 1'b1;
					next_state = gir_pkg::GIR_IDLE;
				end
				else
				begin
					next_load_q = chk_sel;
					next_run_mode = {feature[`GIR_FEAT_ALTERNATE], feature[`GIR_FEAT_RESTRICT]};
					next_state = gir_pkg::GIR_LOAD;
				end
			end
			gir_pkg::GIR_LOAD:
			begin
				next_irq_stat[`GIR_IRQ_PASS] = 1'b1;
				next_state = gir_pkg::GIR_IDLE;
			end
			// The unused code can only come from an upset; it falls back to idle.
			default: next_state = gir_pkg::GIR_IDLE;
		endcase
	end

	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
		begin
			state <= gir_pkg::GIR_IDLE;
			ack <= 1'b0;
			rdata <= `GIR_RST_WORD;
			feature <= `GIR_RST_WORD;
			host_evt <= `GIR_RST_WORD;
			host_vi <= `GIR_RST_DWORD;
			host_shadow <= 1'b0;
			enc_evt <= `GIR_RST_WORD;
			enc_vi <= `GIR_RST_DWORD;
			icpt <= 5'h00;
			exit_code <= `GIR_EXIT_NONE;
			irq_stat <= 3'h0;
			irq_mask <= 3'h0;
			run_mode <= 2'h0;
			load_q <= '0;
		end
		else if (CE)
		begin
			state <= next_state;
			ack <= next_ack;
			rdata <= next_rdata;
			feature <= next_feature;
			host_evt <= next_host_evt;
			host_vi <= next_host_vi;
			host_shadow <= next_host_shadow;
			enc_evt <= next_enc_evt;
			enc_vi <= next_enc_vi;
			icpt <= next_icpt;
			exit_code <= next_exit_code;
			irq_stat <= next_irq_stat;
			irq_mask <= next_irq_mask;
			run_mode <= next_run_mode;
			load_q <= next_load_q;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking @(posedge CLK_SYS iff CE); endclocking
	default disable iff (RESET);

	both_modes_a: assert property (
		state == gir_pkg::GIR_CHECK && feature[`GIR_FEAT_RESTRICT] && feature[`GIR_FEAT_ALTERNATE]
		|=> exit_code == `GIR_EXIT_INVALID && irq_stat[`GIR_IRQ_FAIL] && !LOAD_VALID)
		else $error("both modes did not fail entry");

	restrict_load_a: assert property (
		LOAD_VALID && run_mode[0] |-> !LOAD_STATE.v_irq
		&& (!LOAD_STATE.evt_valid || LOAD_STATE.evt_vector == `GIR_DOORBELL_VEC))
		else $error("restricted entry loaded a forbidden event");

	doorbell_mode_a: assert property (
		LOAD_VALID && LOAD_STATE.evt_valid && LOAD_STATE.evt_vector == `GIR_DOORBELL_VEC
		|-> run_mode == 2'h1)
		else $error("doorbell loaded outside restricted mode");

	doorbell_form_a: assert property (
		LOAD_VALID && LOAD_STATE.evt_valid && LOAD_STATE.evt_vector == `GIR_DOORBELL_VEC
		|-> LOAD_STATE.evt_type == `GIR_TYPE_EXCEPTION && !LOAD_STATE.evt_errv)
		else $error("doorbell loaded with wrong form");

	accel_fail_a: assert property (
		state == gir_pkg::GIR_CHECK && (|feature[`GIR_FEAT_ALTERNATE:`GIR_FEAT_RESTRICT])
		&& host_vi[`GIR_VI_ACCELERATED_VIRTUAL_INT_CTRL] |=> exit_code == `GIR_EXIT_INVALID ##1 !LOAD_VALID)
		else $error("accelerated controller not refused");

	alt_source_a: assert property (
		LOAD_VALID && run_mode[1] |-> LOAD_STATE.evt_vector == $past(enc_evt[7:0])
		&& LOAD_STATE.shadow == $past(enc_vi[`GIR_VI_SHADOW]))
		else $error("alternate entry used the host copy");

	busy_fail_a: assert property (
		state == gir_pkg::GIR_CHECK && feature[`GIR_FEAT_ALTERNATE]
		&& !feature[`GIR_FEAT_RESTRICT] && !host_vi[`GIR_VI_ACCELERATED_VIRTUAL_INT_CTRL] && enc_vi[`GIR_VI_BUSY]
		&& !gir_pkg::gir_is_doorbell(enc_evt)
		|=> exit_code == `GIR_EXIT_BUSY)
		else $error("busy save area was entered");

	writeback_a: assert property (
		EXIT_VALID && run_mode[1] |=> enc_vi[7:0] == $past(EXIT_STATE.virtual_task_priority)
		&& host_shadow == $past(host_shadow))
		else $error("alternate exit wrote the wrong copy");

	entry_clean_a: assert property (
		state == gir_pkg::GIR_CHECK && chk_fail |=> !LOAD_VALID && $stable(LOAD_STATE)
		&& $stable(run_mode))
		else $error("failed entry changed guest state");

endmodule

// ===== testbench/gir_guest_model.sv
/*
 * Guest core model: exits, physical events and register accesses toward the block.
 * Assumes the bench calls its tasks from just after a rising edge of clk.
 */
`timescale 1ns/1ps

module gir_guest_model (
	// Clock
	input wire logic clk,
	// Toward the block
	output logic exit_valid,
	output gir_pkg::gir_exit_t exit_state,
	output gir_pkg::gir_event_t event_in,
	output logic msr_valid,
	output logic [31:0] msr_addr,
	output logic msr_hit
);
	// ****************************************
	// Idle levels
	// ****************************************
	initial
	begin
		exit_valid = 1'b0;
		exit_state = 10'h000;
		event_in = 4'h0;
		msr_valid = 1'b0;
		msr_addr = 32'h0000_0000;
		msr_hit = 1'b0;
	end

	// ****************************************
	// Transfers
	// ****************************************
	// Released fields show the inverse of their last value, so stale data never looks valid.
	task automatic guest_exit(input gir_pkg::gir_exit_t st);
		exit_valid <= 1'b1;
		exit_state <= st;
		@(posedge clk);
		exit_valid <= 1'b0;
		exit_state <= ~st;
	endtask

	task automatic msr_access(input logic [31:0] a, input logic hit);
		msr_valid <= 1'b1;
		msr_addr <= a;
		msr_hit <= hit;
		@(posedge clk);
		msr_valid <= 1'b0;
		msr_addr <= ~a;
		msr_hit <= ~hit;
	endtask

	task automatic set_events(input gir_pkg::gir_event_t ev);
		event_in <= ev;
		@(posedge clk);
	endtask
endmodule

// ===== testbench/guest_injection_restrict_tb.sv
/*
 * Self-checking bench for the guest injection restriction block.
 * Assumes gir_defs.svh on the include path and the guest model beside it.
 */
`timescale 1ns/1ps
`include "gir_defs.svh"

module guest_injection_restrict_tb;
	logic clk_sys;
	logic reset;
	logic [7:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic load_valid;
	gir_pkg::gir_load_t load_state;
	logic exit_valid;
	gir_pkg::gir_exit_t exit_state;
	gir_pkg::gir_event_t event_in;
	gir_pkg::gir_event_t event_exit;
	logic msr_valid;
	logic [31:0] msr_addr;
	logic msr_hit;
	logic msr_exit;
	logic irq;
	int miscompares;
	int checked;
	logic [31:0] rd;
	gir_pkg::gir_load_t got;
	localparam logic [31:0] zero = 32'h0000_0000;

	gir_top u_dut (.CLK_SYS(clk_sys), .RESET(reset), .CE(1'b1), .AVS_ADDRESS(avs_address),
		.AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
		.AVS_BYTEENABLE(avs_byteenable), .AVS_READDATA(avs_readdata),
		.AVS_WAITREQUEST(avs_waitrequest), .LOAD_VALID(load_valid), .LOAD_STATE(load_state),
		.EXIT_VALID(exit_valid), .EXIT_STATE(exit_state), .EVENT_IN(event_in),
		.MSR_VALID(msr_valid), .MSR_ADDR(msr_addr), .MSR_BITMAP_HIT(msr_hit),
		.EVENT_EXIT(event_exit), .MSR_EXIT(msr_exit), .IRQ(irq));

	gir_guest_model u_guest (.clk(clk_sys), .exit_valid(exit_valid), .exit_state(exit_state),
		.event_in(event_in), .msr_valid(msr_valid), .msr_addr(msr_addr), .msr_hit(msr_hit));

	// ****************************************
	// Clock and shared tasks
	// ****************************************
	always #25 clk_sys = ~clk_sys;

	task automatic chk(input logic ok, input string msg);
		checked++;
		if (ok !== 1'b1)
		begin
			miscompares++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask

	task automatic complete_run;
		if (miscompares == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// The request is held until a rising edge sees waitrequest low; read data is taken there.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		avs_write <= wr;
		avs_read <= !wr;
		avs_address <= a;
		avs_writedata <= d;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0)
			@(posedge clk_sys);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	// The host shadow is kept 0 against encrypted bit 10 set, so its source is visible.
	task automatic entry(input logic [31:0] feat, input logic [31:0] hevt,
		input logic [31:0] hvlo, input logic [31:0] ehi, input logic [31:0] code);
		gir_pkg::gir_load_t prev;
		int seen;
		seen = 0;
		bus(1'b1, `GIR_OFS_FEATURE, feat);
		bus(1'b1, `GIR_OFS_HOST_EVT, hevt);
		bus(1'b1, `GIR_OFS_HOST_VI_LO, hvlo);
		bus(1'b1, `GIR_OFS_HOST_VI_HI, 32'h0000_00EE);
		bus(1'b1, `GIR_OFS_HOST_SHADOW, zero);
		bus(1'b1, `GIR_OFS_ENC_EVT, 32'h8000_0305);
		bus(1'b1, `GIR_OFS_ENC_VI_LO, 32'h0017_0655);
		bus(1'b1, `GIR_OFS_ENC_VI_HI, ehi);
		prev = load_state;
		bus(1'b1, `GIR_OFS_CMD, 32'h0000_0001);
		repeat (4)
		begin
			@(negedge clk_sys);
			if (load_valid === 1'b1)
			begin
				seen++;
				got = load_state;
			end
		end
		chk(seen == ((code === `GIR_EXIT_NONE) ? 1 : 0), "load pulse count");
		if (code !== `GIR_EXIT_NONE)
			chk(load_state === prev, "state moved on failed entry");
		bus(1'b0, `GIR_OFS_EXIT_CODE, zero);
		chk(rd === code, "exit code");
		bus(1'b0, `GIR_OFS_IRQ_STAT, zero);
		chk(rd === ((code === `GIR_EXIT_NONE) ? 32'h0000_0001 : 32'h0000_0002), "status");
		bus(1'b1, `GIR_OFS_IRQ_STAT, 32'h0000_0007);
	endtask

	task automatic ev_check(input gir_pkg::gir_event_t exp);
		u_guest.set_events(4'hF);
		@(negedge clk_sys);
		chk(event_exit === exp, "event intercept");
		@(posedge clk_sys);
		u_guest.set_events(4'h0);
	endtask

	task automatic msr_check(input logic [31:0] a, input logic hit, input logic exp);
		@(posedge clk_sys);
		u_guest.msr_access(a, hit);
		@(negedge clk_sys);
		chk(msr_exit === exp, "register access intercept");
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic reset_values;
		for (int a = 0; a <= 'h34; a += 4)
		begin
			bus(1'b0, a[7:0], zero);
			chk(rd === `GIR_RST_WORD, "reset value");
		end
		ev_check(4'h0);
	endtask

	task automatic failures;
		entry(32'h0000_0018, zero, zero, zero, `GIR_EXIT_INVALID);
		entry(32'h0000_0008, 32'h8000_0B1C, zero, zero, `GIR_EXIT_INVALID);
		entry(32'h0000_0008, 32'h8000_001C, zero, zero, `GIR_EXIT_INVALID);
		entry(32'h0000_0008, 32'h8000_0320, zero, zero, `GIR_EXIT_INVALID);
		entry(32'h0000_0008, zero, 32'h8000_0000, zero, `GIR_EXIT_INVALID);
		entry(zero, 32'h8000_031C, zero, zero, `GIR_EXIT_INVALID);
		entry(32'h0000_0010, zero, 32'h8000_0000, zero, `GIR_EXIT_INVALID);
		entry(32'h0000_0010, zero, zero, 32'h8000_0000, `GIR_EXIT_BUSY);
	endtask

	task automatic restricted_pass;
		entry(32'h0000_0008, 32'h8000_031C, 32'h0300_01AA, zero, `GIR_EXIT_NONE);
		chk(got.evt_valid === 1'b1 && got.evt_vector === 8'h1C, "doorbell vector");
		chk(got.v_irq === 1'b0, "host queued request leaked");
		ev_check(4'hF);
	endtask

	task automatic alternate_pass;
		entry(32'h0000_0010, 32'h8000_0321, 32'h0300_01AA, 32'h0000_0033, `GIR_EXIT_NONE);
		chk(got[38:27] === {1'b1, 8'h05, 3'h3}, "encrypted event source");
		chk(got[26:3] === {1'b0, 8'h55, 1'b0, 1'b1, 4'h7, 1'b1, 8'h33}, "enc fields");
		chk(got[2] === 1'b1, "shadow source");
		chk(got[1:0] === 2'b11, "host masking and mode");
		bus(1'b0, `GIR_OFS_FLAGS, zero);
		chk(rd === 32'h0000_0004, "running flags");
		ev_check(4'hF);
		msr_check(`GIR_MSR_LO, 1'b0, 1'b1);
		msr_check(`GIR_MSR_HI, 1'b0, 1'b1);
		msr_check(32'h0000_0900, 1'b1, 1'b0);
		msr_check(32'h0000_07FF, 1'b0, 1'b0);
		bus(1'b1, `GIR_OFS_INTERCEPT, 32'h0000_0010);
		msr_check(32'h0000_0900, 1'b1, 1'b1);
	endtask

	task automatic exit_and_irq;
		bus(1'b1, `GIR_OFS_IRQ_MASK, 32'h0000_0004);
		@(negedge clk_sys);
		chk(irq === 1'b0, "interrupt idle");
		@(posedge clk_sys);
		// The exit shadow is 1 against a host shadow of 0, so a write to the wrong copy shows.
		u_guest.guest_exit({8'h3C, 1'b1, 1'b1});
		@(negedge clk_sys);
		chk(irq === 1'b1, "write-back interrupt");
		bus(1'b0, `GIR_OFS_ENC_VI_LO, zero);
		chk(rd === 32'h0017_073C, "encrypted write-back");
		bus(1'b0, `GIR_OFS_HOST_VI_LO, zero);
		chk(rd === 32'h0300_01AA, "host copy touched");
		bus(1'b0, `GIR_OFS_HOST_SHADOW, zero);
		chk(rd === zero, "host shadow touched");
		bus(1'b1, `GIR_OFS_IRQ_MASK, zero);
		@(negedge clk_sys);
		chk(irq === 1'b0, "masked interrupt");
		bus(1'b1, `GIR_OFS_IRQ_MASK, 32'h0000_0004);
		bus(1'b1, `GIR_OFS_IRQ_STAT, 32'h0000_0004);
		@(negedge clk_sys);
		chk(irq === 1'b0, "cleared interrupt");
		bus(1'b1, 8'h3C, 32'hFFFF_FFFF);
		bus(1'b0, 8'h3C, zero);
		chk(rd === zero, "unmapped read");
	endtask

	// ****************************************
	// Main sequence and watchdog
	// ****************************************
	initial
	begin
		clk_sys = 1'b0;
		reset = 1'b1;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = zero;
		avs_byteenable = 4'hF;
		miscompares = 0;
		checked = 0;
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		reset_values();
		failures();
		restricted_pass();
		alternate_pass();
		exit_and_irq();
		complete_run();
	end

	initial
	begin
		repeat (20000) @(posedge clk_sys);
		miscompares++;
		complete_run();
	end
endmodule
